// ===== src/lpdc_ctrl.sv
// Line transceiver powerdown controller with APB registers
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

// What this block does
// - In any powerdown state the pump enable is low and every transmitter is tristated.
// - With force-off high and sleep inhibit high the block stays active and ignores the timer.
// - Force-off low forces manual powerdown above every other control and any line activity.
// - With receiver disable built in, standard receivers tristate in manual but not auto powerdown.
// - Both controls tied to one signal give a single active-low shutdown with no auto powerdown.
// - After any exit condition the pump and transmitters come back well within 100 us.
// - With inhibit low, manual powerdown ends only on both controls high, a line edge or a software wake.
// - With force-off high, a falling edge of sleep inhibit restarts the full 30 second inactivity timer.
// - With force-off high and inhibit low, 30 s without line edges enters auto powerdown.
// - With the invalid indicator fed to both controls, valid levels mean active, else powerdown.
// - The invalid indicator falls after 30 us of invalid levels on all receivers, in every mode.
// - The invalid indicator rises 1 us after a valid level on any receiver.
// - Once powered down, the timer stays expired until inhibit rises, a line edge comes or software writes the wake bit.
// - The monitor receiver output is enabled at all times.
module lpdc_ctrl #(
  parameter int unsigned NUM_TX    = 3,
  parameter int unsigned NUM_RX    = 5,
  parameter int unsigned INACT_CYC = lpdc_pkg::INACT_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              power_off_force_n,
  input  wire logic              auto_sleep_inhibit,
  input  wire logic [NUM_TX-1:0] tx_in,
  input  wire logic [NUM_RX-1:0] rx_in,
  input  wire logic [NUM_RX-1:0] rx_level_ok,
  output logic                   pump_en_r,
  output logic      [NUM_TX-1:0] tx_oe_n_r,
  output logic      [NUM_RX-1:0] rx_oe_n_r,
  output logic                   monitor_rx_oe_n,
  output logic                   invalid_n_r,
  output logic                   irq_r,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata_r,
  output logic                   pready,
  output logic                   pslverr
);

  // ****************************************************
  // Input synchronisation and edge detection
  // ****************************************************
  localparam int unsigned SW = NUM_TX + 2 * NUM_RX + 2;

  logic [SW-1:0]            sync_s;
  logic                     force_n_s;
  logic                     inhib_s;
  logic                     inhib_d_r;
  logic [NUM_TX+NUM_RX-1:0] line_s;
  logic [NUM_TX+NUM_RX-1:0] line_d_r;
  logic [NUM_RX-1:0]        lvl_ok_s;
  logic                     line_edge;
  logic                     all_invalid;
  logic                     any_valid;

  lpdc_sync #(.WIDTH(SW)) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in ({power_off_force_n, auto_sleep_inhibit, tx_in, rx_in, rx_level_ok}),
    .sync_r   (sync_s)
  );

  assign force_n_s   = sync_s[SW-1];
  assign inhib_s     = sync_s[SW-2];
  assign line_s      = sync_s[SW-3:NUM_RX];
  assign lvl_ok_s    = sync_s[NUM_RX-1:0];
  assign line_edge   = |(line_s ^ line_d_r);
  assign all_invalid = ~|lvl_ok_s;
  assign any_valid   = |lvl_ok_s;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      line_d_r  <= '0;
      inhib_d_r <= 1'b0;
    end else if (clk_en) begin
      line_d_r  <= line_s;
      inhib_d_r <= inhib_s;
    end
  end

  // ****************************************************
  // Registers written by software
  // ****************************************************
  logic                    ctrl_rxdis_r;
  logic                    soft_wake;
  logic [lpdc_pkg::EV_W-1:0] int_stat_r;
  logic [lpdc_pkg::EV_W-1:0] int_mask_r;
  logic [lpdc_pkg::EV_W-1:0] ev_set;
  logic                    wr_acc;
  logic                    mapped;

  assign wr_acc    = psel && penable && pwrite;
  assign soft_wake = wr_acc && (paddr == lpdc_pkg::CTRL_OFS)
                     && pwdata[lpdc_pkg::CTRL_WAKE_BIT];
  assign mapped    = (paddr == lpdc_pkg::CTRL_OFS) || (paddr == lpdc_pkg::STATUS_OFS)
                     || (paddr == lpdc_pkg::INT_STAT_OFS) || (paddr == lpdc_pkg::INT_MASK_OFS);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_rxdis_r <= lpdc_pkg::CTRL_RXDIS_RST;
      int_mask_r   <= lpdc_pkg::INT_MASK_RST;
    end else if (clk_en && wr_acc) begin
      if (paddr == lpdc_pkg::CTRL_OFS) begin
        ctrl_rxdis_r <= pwdata[lpdc_pkg::CTRL_RXDIS_BIT];
      end
      if (paddr == lpdc_pkg::INT_MASK_OFS) begin
        int_mask_r <= pwdata[lpdc_pkg::EV_W-1:0];
      end
    end
  end

  // ****************************************************
  // Inactivity timer
  // ****************************************************
  lpdc_pkg::lpdc_mode_t mode_r;
  lpdc_pkg::lpdc_mode_t mode_nxt;
  logic                 tmr_exp;

  // Edge, inhibit high or software wake restarts; manual powerdown sets
  lpdc_delay #(.LIMIT(INACT_CYC)) u_inact (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .clr     (line_edge || inhib_s || soft_wake),
    .set     (mode_r == lpdc_pkg::LPDC_MANUAL_PD),
    .done_r  (tmr_exp)
  );

  // ****************************************************
  // Power mode
  // ****************************************************
  always_comb begin
    if (!force_n_s) begin
      mode_nxt = lpdc_pkg::LPDC_MANUAL_PD;
    end else if (inhib_s) begin
      mode_nxt = lpdc_pkg::LPDC_ACTIVE;
    end else if (tmr_exp) begin
      mode_nxt = lpdc_pkg::LPDC_AUTO_PD;
    end else begin
      mode_nxt = lpdc_pkg::LPDC_ACTIVE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_r    <= lpdc_pkg::LPDC_ACTIVE;
      pump_en_r <= 1'b1;
      tx_oe_n_r <= '0;
      rx_oe_n_r <= '0;
    end else if (clk_en) begin
      mode_r    <= mode_nxt;
      pump_en_r <= (mode_nxt == lpdc_pkg::LPDC_ACTIVE);
      tx_oe_n_r <= {NUM_TX{mode_nxt != lpdc_pkg::LPDC_ACTIVE}};
      rx_oe_n_r <= {NUM_RX{ctrl_rxdis_r && (mode_nxt == lpdc_pkg::LPDC_MANUAL_PD)}};
    end
  end

  assign monitor_rx_oe_n = 1'b0;

  // ****************************************************
  // Invalid level indicator
  // ****************************************************
  logic inv_done;
  logic val_done;

  lpdc_delay #(.LIMIT(lpdc_pkg::INVALID_CYC)) u_inv (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .clr     (!(all_invalid && invalid_n_r)),
    .set     (1'b0),
    .done_r  (inv_done)
  );

  lpdc_delay #(.LIMIT(lpdc_pkg::VALID_CYC)) u_val (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .clr     (!(any_valid && !invalid_n_r)),
    .set     (1'b0),
    .done_r  (val_done)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      invalid_n_r <= 1'b1;
    end else if (clk_en) begin
      if (inv_done && all_invalid) begin
        invalid_n_r <= 1'b0;
      end else if (val_done && any_valid) begin
        invalid_n_r <= 1'b1;
      end
    end
  end

  // ****************************************************
  // Interrupt status, mask and output
  // ****************************************************
  always_comb begin
    ev_set = '0;
    ev_set[lpdc_pkg::EV_PD_ENTER] = (mode_r == lpdc_pkg::LPDC_ACTIVE)
                                    && (mode_nxt != lpdc_pkg::LPDC_ACTIVE);
    ev_set[lpdc_pkg::EV_PD_EXIT]  = (mode_r != lpdc_pkg::LPDC_ACTIVE)
                                    && (mode_nxt == lpdc_pkg::LPDC_ACTIVE);
    ev_set[lpdc_pkg::EV_INV_FALL] = invalid_n_r && inv_done && all_invalid;
    ev_set[lpdc_pkg::EV_INV_RISE] = !invalid_n_r && val_done && any_valid;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      int_stat_r <= '0;
      irq_r      <= 1'b0;
    end else if (clk_en) begin
      if (wr_acc && (paddr == lpdc_pkg::INT_STAT_OFS)) begin
        int_stat_r <= (int_stat_r & ~pwdata[lpdc_pkg::EV_W-1:0]) | ev_set;
      end else begin
        int_stat_r <= int_stat_r | ev_set;
      end
      irq_r <= |(int_stat_r & int_mask_r);
    end
  end

  // ****************************************************
  // APB read path
  // ****************************************************
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      unique case (paddr)
        lpdc_pkg::CTRL_OFS: begin
          prdata_r[lpdc_pkg::CTRL_RXDIS_BIT] <= ctrl_rxdis_r;
        end
        lpdc_pkg::STATUS_OFS: begin
          prdata_r[lpdc_pkg::ST_MODE_LSB +: 2]     <= mode_r;
          prdata_r[lpdc_pkg::ST_INVALID_BIT]       <= invalid_n_r;
          prdata_r[lpdc_pkg::ST_PUMP_BIT]          <= pump_en_r;
          prdata_r[lpdc_pkg::ST_TMR_BIT]           <= tmr_exp;
          prdata_r[lpdc_pkg::ST_FORCE_BIT]         <= force_n_s;
          prdata_r[lpdc_pkg::ST_INHIB_BIT]         <= inhib_s;
        end
        lpdc_pkg::INT_STAT_OFS: begin
          prdata_r[lpdc_pkg::EV_W-1:0] <= int_stat_r;
        end
        lpdc_pkg::INT_MASK_OFS: begin
          prdata_r[lpdc_pkg::EV_W-1:0] <= int_mask_r;
        end
        default: begin
          prdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst || !clk_en);

  sequence quiet_auto_s;
    force_n_s && !inhib_s && !line_edge && !soft_wake;
  endsequence

  sequence manual_hold_s;
    (mode_r == lpdc_pkg::LPDC_MANUAL_PD) ##1 quiet_auto_s;
  endsequence

  pd_outputs_off_a: assert property (
    (mode_r != lpdc_pkg::LPDC_ACTIVE) |-> (!pump_en_r && (&tx_oe_n_r)))
    else $error("Pump or transmitter on in powerdown");

  forced_on_a: assert property (
    (force_n_s && inhib_s) |=> (mode_r == lpdc_pkg::LPDC_ACTIVE) && pump_en_r)
    else $error("Not active with both controls high");

  force_off_a: assert property (
    (!force_n_s) |=> (mode_r == lpdc_pkg::LPDC_MANUAL_PD) && (&tx_oe_n_r))
    else $error("Force-off low did not force manual powerdown");

  rx_disable_a: assert property (
    (mode_r == lpdc_pkg::LPDC_AUTO_PD) |-> (rx_oe_n_r == '0))
    else $error("Receivers disabled during auto powerdown");

  rx_manual_a: assert property (
    (mode_r == lpdc_pkg::LPDC_MANUAL_PD) && $stable(ctrl_rxdis_r) |->
      (rx_oe_n_r == {NUM_RX{ctrl_rxdis_r}}))
    else $error("Receiver enable wrong in manual powerdown");

  recover_a: assert property (
    (force_n_s && (inhib_s || line_edge)) ##1 force_n_s |-> ##[0:1] pump_en_r)
    else $error("No recovery after exit condition");

  manual_exit_a: assert property (
    manual_hold_s ##0 !$past(line_edge) ##0 !$past(soft_wake) ##0 !$past(inhib_s)
      |=> (mode_r != lpdc_pkg::LPDC_ACTIVE))
    else $error("Left manual powerdown without exit condition");

  timer_restart_a: assert property (
    ($fell(inhib_s) && $past(force_n_s) && force_n_s) |-> !tmr_exp ##1 !tmr_exp)
    else $error("Timer not restarted on inhibit fall");

  auto_enter_a: assert property (
    (tmr_exp && force_n_s && !inhib_s) |=> (mode_r == lpdc_pkg::LPDC_AUTO_PD))
    else $error("Timeout did not enter auto powerdown");

  invalid_fall_a: assert property (
    (invalid_n_r && !all_invalid) |=> invalid_n_r)
    else $error("Indicator fell with a valid level present");

  invalid_rise_a: assert property (
    (!invalid_n_r && !any_valid) |=> !invalid_n_r)
    else $error("Indicator rose with no valid level");

  timer_hold_a: assert property (
    (quiet_auto_s ##0 tmr_exp) |=> tmr_exp)
    else $error("Expired timer cleared without cause");

  monitor_on_a: assert property (
    monitor_rx_oe_n == 1'b0)
    else $error("Monitor receiver disabled");

endmodule // lpdc_ctrl

// ===== src/lpdc_pkg.sv
// Constants shared by the line powerdown controller
package lpdc_pkg;

  // ****************************************************
  // Timebase
  // ****************************************************
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;

  // Line inactivity timeout, in seconds
  localparam int unsigned INACT_TIME_S  = 30;
  localparam int unsigned INACT_CYC     = 32'(64'(INACT_TIME_S) * 64'(CLK_HZ));
  // Invalid level persistence, least time, in ns
  localparam int unsigned INVALID_TIME_NS = 30_000;
  localparam int unsigned INVALID_CYC   =
    (INVALID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Valid level to indicator high, in ns
  localparam int unsigned VALID_TIME_NS = 1_000;
  localparam int unsigned VALID_CYC     =
    (VALID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest powerdown exit to transmit, in ns
  localparam int unsigned RECOVER_TIME_NS = 100_000;
  localparam int unsigned RECOVER_CYC   = RECOVER_TIME_NS / CLK_PERIOD_NS;

  // ****************************************************
  // Register map (byte addresses)
  // ****************************************************
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] INT_STAT_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0C;

  // CTRL fields
  localparam int unsigned CTRL_RXDIS_BIT = 0;
  localparam int unsigned CTRL_WAKE_BIT  = 1;
  localparam logic        CTRL_RXDIS_RST = 1'b1;

  // STATUS fields
  localparam int unsigned ST_MODE_LSB    = 0;
  localparam int unsigned ST_INVALID_BIT = 2;
  localparam int unsigned ST_PUMP_BIT    = 3;
  localparam int unsigned ST_TMR_BIT     = 4;
  localparam int unsigned ST_FORCE_BIT   = 5;
  localparam int unsigned ST_INHIB_BIT   = 6;

  // Interrupt events
  localparam int unsigned EV_W           = 4;
  localparam int unsigned EV_PD_ENTER    = 0;
  localparam int unsigned EV_PD_EXIT     = 1;
  localparam int unsigned EV_INV_FALL    = 2;
  localparam int unsigned EV_INV_RISE    = 3;
  localparam logic [3:0]  INT_MASK_RST   = 4'h0;

  typedef enum logic [1:0] {
    LPDC_ACTIVE    = 2'b00,
    LPDC_AUTO_PD   = 2'b01,
    LPDC_MANUAL_PD = 2'b10
  } lpdc_mode_t;

endpackage

// ===== src/lpdc_sync.sv
// Two-stage synchroniser for a vector of levels
`timescale 1ns/1ps
module lpdc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_r
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (clk_en) begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
endmodule // lpdc_sync

// ===== src/lpdc_delay.sv
// Sticky delay counter: done after LIMIT cycles without clear
`timescale 1ns/1ps
module lpdc_delay #(
  parameter int unsigned LIMIT = 4
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic clr,
  input  wire logic set,
  output logic      done_r
);
  localparam int unsigned WIDTH = $clog2(LIMIT + 1);

  logic [WIDTH-1:0] cnt_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (clk_en) begin
      if (clr) begin
        cnt_r  <= '0;
        done_r <= 1'b0;
      end else if (set) begin
        done_r <= 1'b1;
      end else if (!done_r) begin
        if (cnt_r == WIDTH'(LIMIT - 1)) begin
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + WIDTH'(1);
        end
      end
    end
  end
endmodule // lpdc_delay

// ===== bench/lpdc_host.sv
// Host power-management model driving the two force controls
`timescale 1ns/1ps
module lpdc_host (
  input  wire logic       clk_sys,
  input  wire logic [1:0] wiring,
  input  wire logic       off_req_n,
  input  wire logic       inhib_req,
  input  wire logic       invalid_n_r,
  output logic            power_off_force_n,
  output logic            auto_sleep_inhibit
);
  logic force_q = 1'b1;
  logic inhib_q = 1'b1;

  // ****************************************************
  // Wiring: 0 separate, 1 tied together, 2 indicator loop
  // ****************************************************
  always @(posedge clk_sys) begin
    case (wiring)
      2'h1: begin
        force_q <= off_req_n;
        inhib_q <= off_req_n;
      end
      2'h2: begin
        force_q <= invalid_n_r;
        inhib_q <= invalid_n_r;
      end
      default: begin
        force_q <= off_req_n;
        inhib_q <= inhib_req;
      end
    endcase
  end

  assign power_off_force_n  = force_q;
  assign auto_sleep_inhibit = inhib_q;
endmodule // lpdc_host

// ===== bench/lpdc_ctrl_tb.sv
// Self-checking bench for the line powerdown controller
`timescale 1ns/1ps
module lpdc_ctrl_tb;
  localparam int unsigned INACT = 200;
  localparam int          REC   = lpdc_pkg::RECOVER_CYC;
  logic        clk_sys     = 1'b0;
  logic        sys_rst     = 1'b1;
  logic [2:0]  tx_in       = 3'h0;
  logic [4:0]  rx_in       = 5'h00;
  logic [4:0]  rx_level_ok = 5'h1F;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0000_0000;
  logic [1:0]  wiring      = 2'h0;
  logic        off_req_n   = 1'b1;
  logic        inhib_req   = 1'b1;
  logic        force_n, inhibit, pump_en_r, monitor_rx_oe_n, invalid_n_r, irq_r;
  logic        pready, pslverr, rd_err;
  logic [2:0]  tx_oe_n_r;
  logic [4:0]  rx_oe_n_r;
  logic [31:0] prdata_r, rd;
  int          err_total = 0;
  int          checked   = 0;

  always #20 clk_sys = ~clk_sys;

  lpdc_host host_i (.clk_sys(clk_sys), .wiring(wiring), .off_req_n(off_req_n),
    .inhib_req(inhib_req), .invalid_n_r(invalid_n_r), .power_off_force_n(force_n),
    .auto_sleep_inhibit(inhibit));

  lpdc_ctrl #(.NUM_TX(3), .NUM_RX(5), .INACT_CYC(INACT)) dut (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .clk_en(1'b1), .power_off_force_n(force_n),
    .auto_sleep_inhibit(inhibit), .tx_in(tx_in), .rx_in(rx_in), .rx_level_ok(rx_level_ok),
    .pump_en_r(pump_en_r), .tx_oe_n_r(tx_oe_n_r), .rx_oe_n_r(rx_oe_n_r),
    .monitor_rx_oe_n(monitor_rx_oe_n), .invalid_n_r(invalid_n_r), .irq_r(irq_r),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_r(prdata_r), .pready(pready), .pslverr(pslverr));

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd      = prdata_r;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h0000_0001, 32'(pready));
    #1;
  endtask

  task automatic host(input logic [1:0] w, input logic off, input logic inh);
    @(posedge clk_sys);
    wiring    <= w;
    off_req_n <= off;
    inhib_req <= inh;
  endtask

  task automatic pins(input logic pd, input logic rx_off);
    chk("pump", 32'(!pd), 32'(pump_en_r));
    chk("tx oe", pd ? 32'h0000_0007 : 32'h0000_0000, 32'(tx_oe_n_r));
    chk("rx oe", rx_off ? 32'h0000_001F : 32'h0000_0000, 32'(rx_oe_n_r));
    chk("monitor oe", 32'h0000_0000, 32'(monitor_rx_oe_n));
  endtask

  task automatic mode_is(input lpdc_pkg::lpdc_mode_t m);
    apb(1'b0, lpdc_pkg::STATUS_OFS, 32'h0000_0000);
    chk("mode", 32'(m), 32'(rd[1:0]));
  endtask

  task automatic wait_pump(input logic exp, input int lim);
    int n;
    n = 0;
    while (pump_en_r !== exp && n < lim) begin
      cyc(1);
      n++;
    end
    chk("pump wait", 32'(exp), 32'(pump_en_r));
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cyc(8);
    apb(1'b0, lpdc_pkg::CTRL_OFS, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0001, rd);
    apb(1'b0, lpdc_pkg::INT_MASK_OFS, 32'h0000_0000);
    chk("mask reset", 32'h0000_0000, rd);
    apb(1'b1, 8'h10, 32'h0000_FFFF);
    chk("unmapped err", 32'h0000_0001, 32'(rd_err));
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    pins(1'b0, 1'b0);
    $display("test reset done");

    host(2'h0, 1'b0, 1'b1);
    cyc(8);
    pins(1'b1, 1'b1);
    mode_is(lpdc_pkg::LPDC_MANUAL_PD);
    @(posedge clk_sys) tx_in <= 3'h1;
    cyc(8);
    pins(1'b1, 1'b1);
    apb(1'b1, lpdc_pkg::CTRL_OFS, 32'h0000_0000);
    cyc(3);
    pins(1'b1, 1'b0);
    apb(1'b1, lpdc_pkg::CTRL_OFS, 32'h0000_0001);
    $display("test manual done");

    host(2'h0, 1'b1, 1'b1);
    wait_pump(1'b1, REC);
    cyc(INACT + 100);
    pins(1'b0, 1'b0);
    $display("test forced on done");

    host(2'h0, 1'b1, 1'b0);
    cyc(INACT - 20);
    pins(1'b0, 1'b0);
    cyc(60);
    pins(1'b1, 1'b0);
    mode_is(lpdc_pkg::LPDC_AUTO_PD);
    cyc(INACT + 50);
    pins(1'b1, 1'b0);
    @(posedge clk_sys) rx_in <= 5'h02;
    wait_pump(1'b1, REC);
    cyc(INACT - 20);
    pins(1'b0, 1'b0);
    host(2'h0, 1'b0, 1'b0);
    cyc(8);
    host(2'h0, 1'b1, 1'b0);
    cyc(40);
    pins(1'b1, 1'b0);
    @(posedge clk_sys) tx_in <= 3'h3;
    wait_pump(1'b1, REC);
    cyc(INACT + 20);
    pins(1'b1, 1'b0);
    apb(1'b1, lpdc_pkg::CTRL_OFS, 32'h0000_0003);
    wait_pump(1'b1, REC);
    $display("test auto done");

    apb(1'b1, lpdc_pkg::INT_STAT_OFS, 32'h0000_000F);
    host(2'h1, 1'b0, 1'b0);
    cyc(8);
    pins(1'b1, 1'b1);
    chk("irq masked", 32'h0000_0000, 32'(irq_r));
    apb(1'b0, lpdc_pkg::INT_STAT_OFS, 32'h0000_0000);
    chk("pd entered", 32'h0000_0001, 32'(rd[0]));
    apb(1'b1, lpdc_pkg::INT_MASK_OFS, 32'h0000_0001);
    cyc(3);
    chk("irq raised", 32'h0000_0001, 32'(irq_r));
    apb(1'b1, lpdc_pkg::INT_STAT_OFS, 32'h0000_0001);
    cyc(3);
    chk("irq cleared", 32'h0000_0000, 32'(irq_r));
    host(2'h1, 1'b1, 1'b0);
    wait_pump(1'b1, REC);
    cyc(INACT + 50);
    pins(1'b0, 1'b0);
    $display("test tied done");

    host(2'h2, 1'b1, 1'b1);
    rx_level_ok <= 5'h00;
    cyc(700);
    chk("invalid early", 32'h0000_0001, 32'(invalid_n_r));
    pins(1'b0, 1'b0);
    cyc(100);
    chk("invalid low", 32'h0000_0000, 32'(invalid_n_r));
    cyc(8);
    pins(1'b1, 1'b1);
    @(posedge clk_sys) rx_level_ok <= 5'h04;
    cyc(10);
    chk("valid early", 32'h0000_0000, 32'(invalid_n_r));
    cyc(30);
    chk("valid high", 32'h0000_0001, 32'(invalid_n_r));
    wait_pump(1'b1, REC);
    $display("test loop done");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    $display("[ERR] watchdog expected done seen timeout");
    end_of_test();
  end
endmodule // lpdc_ctrl_tb
